/* File: rtl/cpps_pkg.sv */
// constants and types for the configuration pin sharing block
// Summary of operation
// - master flash mode: commands and data leave on lane 0; lane 0 in wider modes
// - master flash mode: serial input arrives on lane 1; lane 1 in wider modes
// - master lanes 2 and 3 carry data bits two and three in quad only
// - chain select output is driven only once done and configuration complete
// - chain bypass output is not provided; bypass chaining is unsupported
// - jtag shifts data in on rising tck and out on falling tck
// - test port logic is static; state holds while tck stands still
// - tms sampled on rising tck steps the tap state machine
// - tdo floats except in shift-ir and shift-dr, where it is driven
// - slave serial mode uses the shared tck pin as slave port clock
// - slave port select is active low; the spi slave answers only while low, i2c and jtag drive regardless
// - slave serial input arrives on the tdi pin; lane 0 in wider modes
// - slave read data leaves on the tdo pin; lane 1 in wider modes
// - slave lanes 2 and 3 carry data bits two and three in quad only
// - slave i2c/i3c mode uses slave lanes 2 and 3 as scl and sda
// - keep-after-boot bits decide which ports keep their role in user mode
// - kept master group: quad keeps four lanes, serial and dual keep two
// - kept slave group: quad keeps four lanes, serial and dual keep two
// - jtag role in user mode follows the jtag enable pin only
package cpps_pkg;

  typedef logic [3:0] cpps_lane_t;
  typedef logic [3:0] cpps_ir_t;

  localparam int unsigned CPPS_D0 = 0;
  localparam int unsigned CPPS_D1 = 1;
  localparam int unsigned CPPS_D2 = 2;
  localparam int unsigned CPPS_D3 = 3;

  localparam cpps_ir_t CPPS_IR_CAPTURE = 4'h1;
  localparam cpps_ir_t CPPS_IR_BYPASS  = 4'hf;

  typedef enum logic [3:0] {
    CPPS_MODE_NONE   = 4'h0,
    CPPS_MSTR_SERIAL = 4'h1,
    CPPS_MSTR_DUAL   = 4'h2,
    CPPS_MSTR_QUAD   = 4'h3,
    CPPS_SLV_SERIAL  = 4'h4,
    CPPS_SLV_DUAL    = 4'h5,
    CPPS_SLV_QUAD    = 4'h6,
    CPPS_SLV_I2C     = 4'h7
  } cpps_mode_e;

  typedef enum logic [1:0] {
    CPPS_W_OFF    = 2'h0,
    CPPS_W_SERIAL = 2'h1,
    CPPS_W_DUAL   = 2'h2,
    CPPS_W_QUAD   = 2'h3
  } cpps_width_e;

  typedef enum logic [3:0] {
    CPPS_TAP_TLR  = 4'h0, CPPS_TAP_RTI  = 4'h1, CPPS_TAP_SDRS = 4'h2,
    CPPS_TAP_CDR  = 4'h3, CPPS_TAP_SDR  = 4'h4, CPPS_TAP_E1DR = 4'h5,
    CPPS_TAP_PDR  = 4'h6, CPPS_TAP_E2DR = 4'h7, CPPS_TAP_UDR  = 4'h8,
    CPPS_TAP_SIRS = 4'h9, CPPS_TAP_CIR  = 4'ha, CPPS_TAP_SIR  = 4'hb,
    CPPS_TAP_E1IR = 4'hc, CPPS_TAP_PIR  = 4'hd, CPPS_TAP_E2IR = 4'he,
    CPPS_TAP_UIR  = 4'hf
  } cpps_tap_e;

  typedef struct packed {
    cpps_width_e master;
    cpps_width_e slave_spi;
    logic        i2c;
  } cpps_keep_s;

  typedef struct packed {
    logic       tck_s1, tck_s2, tck_d;
    logic       sel_s1, sel_s2, jen_s1, jen_s2;
    cpps_lane_t sl_s1, sl_s2, ml_s1, ml_s2;
    cpps_tap_e  tap;
    cpps_ir_t   ir, ir_sh;
    logic       dr_sh, tdo, tdo_en;
    cpps_lane_t slv_din, sl_o, sl_oe_n, ml_o, ml_oe_n, mst_din;
    logic       m_clk, m_clk_oe_n, m_sel, m_sel_oe_n;
    logic       chain, chain_oe_n, scl, sda;
  } cpps_state_s;

  localparam cpps_state_s CPPS_ST_RST = '{
    tap: CPPS_TAP_TLR, ir: CPPS_IR_BYPASS, sel_s1: 1'b1, sel_s2: 1'b1,
    sl_oe_n: 4'hf, ml_oe_n: 4'hf, m_clk_oe_n: 1'b1, m_sel: 1'b1,
    m_sel_oe_n: 1'b1, chain: 1'b1, chain_oe_n: 1'b1, scl: 1'b1, sda: 1'b1,
    default: '0};

endpackage : cpps_pkg

/* File: rtl/cpps_top.sv */
// configuration pin sharing: master flash, jtag, slave serial and i2c pins
`timescale 1ns/1ps
`default_nettype none
module cpps_top (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire cpps_pkg::cpps_mode_e  cfg_mode_i,
  input  wire logic                  user_mode_i,
  input  wire cpps_pkg::cpps_keep_s  keep_after_boot_bits_i,
  input  wire logic                  done_bit_i,
  input  wire logic                  cfg_complete_i,
  input  wire logic                  jtag_en_pin_i,
  input  wire logic                  mst_clk_i,
  input  wire logic                  mst_sel_n_i,
  input  wire cpps_pkg::cpps_lane_t  mst_dout_i,
  input  wire cpps_pkg::cpps_lane_t  mst_doe_i,
  output logic [3:0]                 mst_din_o,
  output logic                       master_clk_o,
  output logic                       master_clk_oe_n_o,
  output logic                       master_flash_select_n_o,
  output logic                       master_flash_select_oe_n_o,
  input  wire cpps_pkg::cpps_lane_t  master_lane_i,
  output logic [3:0]                 master_lane_o,
  output logic [3:0]                 master_lane_oe_n_o,
  output logic                       chain_select_out_o,
  output logic                       chain_select_oe_n_o,
  input  wire logic                  slave_port_clock_i,
  input  wire logic                  slave_port_select_n_i,
  input  wire cpps_pkg::cpps_lane_t  slave_lane_i,
  output logic [3:0]                 slave_lane_o,
  output logic [3:0]                 slave_lane_oe_n_o,
  output logic                       slv_clk_rise_o,
  output logic                       slv_clk_fall_o,
  output logic                       slv_sel_o,
  output logic [3:0]                 slv_din_o,
  input  wire cpps_pkg::cpps_lane_t  slv_dout_i,
  input  wire cpps_pkg::cpps_lane_t  slv_doe_i,
  output logic                       i2c_active_o,
  output logic                       i2c_scl_o,
  output logic                       i2c_sda_o,
  input  wire logic                  i2c_scl_hold_i,
  input  wire logic                  i2c_sda_pull_i,
  output cpps_pkg::cpps_tap_e        tap_state_o,
  output logic [3:0]                 jtag_ir_o,
  output logic                       jtag_active_o
);

  // ****************************************
  // mode decode
  // ****************************************
  function automatic cpps_pkg::cpps_width_e mode_width(input cpps_pkg::cpps_mode_e m,
                                                       input logic slave);
    cpps_pkg::cpps_width_e w;
    w = cpps_pkg::CPPS_W_OFF;
    case (m)
      cpps_pkg::CPPS_MSTR_SERIAL: w = slave ? cpps_pkg::CPPS_W_OFF : cpps_pkg::CPPS_W_SERIAL;
      cpps_pkg::CPPS_MSTR_DUAL:   w = slave ? cpps_pkg::CPPS_W_OFF : cpps_pkg::CPPS_W_DUAL;
      cpps_pkg::CPPS_MSTR_QUAD:   w = slave ? cpps_pkg::CPPS_W_OFF : cpps_pkg::CPPS_W_QUAD;
      cpps_pkg::CPPS_SLV_SERIAL:  w = slave ? cpps_pkg::CPPS_W_SERIAL : cpps_pkg::CPPS_W_OFF;
      cpps_pkg::CPPS_SLV_DUAL:    w = slave ? cpps_pkg::CPPS_W_DUAL : cpps_pkg::CPPS_W_OFF;
      cpps_pkg::CPPS_SLV_QUAD:    w = slave ? cpps_pkg::CPPS_W_QUAD : cpps_pkg::CPPS_W_OFF;
      default:                    w = cpps_pkg::CPPS_W_OFF;
    endcase
    return w;
  endfunction : mode_width

  cpps_pkg::cpps_state_s st_ff;
  cpps_pkg::cpps_state_s nxt_st;

  cpps_pkg::cpps_width_e mst_w;
  cpps_pkg::cpps_width_e slv_w;
  logic                  jtag_act;
  logic                  i2c_act;
  logic                  tck_rise;
  logic                  tck_fall;
  logic                  slv_sel;
  logic                  tap_shift;

  always_comb begin
    jtag_act = st_ff.jen_s2;
    mst_w    = user_mode_i ? keep_after_boot_bits_i.master
                           : mode_width(cfg_mode_i, 1'b0);
    slv_w    = jtag_act ? cpps_pkg::CPPS_W_OFF
             : (user_mode_i ? keep_after_boot_bits_i.slave_spi
                            : mode_width(cfg_mode_i, 1'b1));
    i2c_act  = !jtag_act && (slv_w != cpps_pkg::CPPS_W_QUAD)
             && (user_mode_i ? keep_after_boot_bits_i.i2c
                             : (cfg_mode_i == cpps_pkg::CPPS_SLV_I2C));
    tck_rise = st_ff.tck_s2 && !st_ff.tck_d;
    tck_fall = !st_ff.tck_s2 && st_ff.tck_d;
    slv_sel  = (slv_w != cpps_pkg::CPPS_W_OFF) && !st_ff.sel_s2;
    tap_shift = (st_ff.tap == cpps_pkg::CPPS_TAP_SIR) || (st_ff.tap == cpps_pkg::CPPS_TAP_SDR);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tck_s1 = slave_port_clock_i;
    nxt_st.tck_s2 = st_ff.tck_s1;
    nxt_st.tck_d  = st_ff.tck_s2;
    nxt_st.sel_s1 = slave_port_select_n_i;
    nxt_st.sel_s2 = st_ff.sel_s1;
    nxt_st.jen_s1 = jtag_en_pin_i;
    nxt_st.jen_s2 = st_ff.jen_s1;
    nxt_st.sl_s1  = slave_lane_i;
    nxt_st.sl_s2  = st_ff.sl_s1;
    nxt_st.ml_s1  = master_lane_i;
    nxt_st.ml_s2  = st_ff.ml_s1;

    // tap: acts only on a detected tck edge, so a stopped clock holds all
    if (jtag_act && tck_rise) begin
      case (st_ff.tap)
        cpps_pkg::CPPS_TAP_TLR: nxt_st.ir = cpps_pkg::CPPS_IR_BYPASS;
        cpps_pkg::CPPS_TAP_CIR: nxt_st.ir_sh = cpps_pkg::CPPS_IR_CAPTURE;
        cpps_pkg::CPPS_TAP_SIR:
          nxt_st.ir_sh = {st_ff.sl_s2[cpps_pkg::CPPS_D0], st_ff.ir_sh[3:1]};
        cpps_pkg::CPPS_TAP_UIR: nxt_st.ir = st_ff.ir_sh;
        cpps_pkg::CPPS_TAP_CDR: nxt_st.dr_sh = 1'b0;
        cpps_pkg::CPPS_TAP_SDR: nxt_st.dr_sh = st_ff.sl_s2[cpps_pkg::CPPS_D0];
        default: nxt_st.dr_sh = st_ff.dr_sh;
      endcase
      case (st_ff.tap)
        cpps_pkg::CPPS_TAP_TLR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_TLR : cpps_pkg::CPPS_TAP_RTI;
        cpps_pkg::CPPS_TAP_RTI, cpps_pkg::CPPS_TAP_UDR, cpps_pkg::CPPS_TAP_UIR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_SDRS : cpps_pkg::CPPS_TAP_RTI;
        cpps_pkg::CPPS_TAP_SDRS:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_SIRS : cpps_pkg::CPPS_TAP_CDR;
        cpps_pkg::CPPS_TAP_CDR, cpps_pkg::CPPS_TAP_SDR, cpps_pkg::CPPS_TAP_E2DR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_E1DR : cpps_pkg::CPPS_TAP_SDR;
        cpps_pkg::CPPS_TAP_E1DR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_UDR : cpps_pkg::CPPS_TAP_PDR;
        cpps_pkg::CPPS_TAP_PDR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_E2DR : cpps_pkg::CPPS_TAP_PDR;
        cpps_pkg::CPPS_TAP_SIRS:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_TLR : cpps_pkg::CPPS_TAP_CIR;
        cpps_pkg::CPPS_TAP_CIR, cpps_pkg::CPPS_TAP_SIR, cpps_pkg::CPPS_TAP_E2IR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_E1IR : cpps_pkg::CPPS_TAP_SIR;
        cpps_pkg::CPPS_TAP_E1IR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_UIR : cpps_pkg::CPPS_TAP_PIR;
        cpps_pkg::CPPS_TAP_PIR:
          nxt_st.tap = st_ff.sel_s2 ? cpps_pkg::CPPS_TAP_E2IR : cpps_pkg::CPPS_TAP_PIR;
        default: nxt_st.tap = cpps_pkg::CPPS_TAP_TLR;
      endcase
    end
    if (jtag_act && tck_fall) begin
      nxt_st.tdo    = (st_ff.tap == cpps_pkg::CPPS_TAP_SIR) ? st_ff.ir_sh[0] : st_ff.dr_sh;
      nxt_st.tdo_en = tap_shift;
    end
    if (!jtag_act) begin
      nxt_st.tdo_en = 1'b0;
    end

    // slave serial: capture on rising, present on falling clock
    if (slv_sel && tck_rise) begin
      nxt_st.slv_din = st_ff.sl_s2;
    end
    nxt_st.sl_oe_n = 4'hf;
    if (slv_sel && tck_fall) begin
      nxt_st.sl_o = slv_dout_i;
    end
    if (jtag_act) begin
      nxt_st.sl_o[cpps_pkg::CPPS_D1]    = nxt_st.tdo;
      nxt_st.sl_oe_n[cpps_pkg::CPPS_D1] = !nxt_st.tdo_en;
    end else if (slv_sel) begin
      nxt_st.sl_oe_n[cpps_pkg::CPPS_D1] = (slv_w == cpps_pkg::CPPS_W_SERIAL) ? 1'b0
                                        : !slv_doe_i[cpps_pkg::CPPS_D1];
      nxt_st.sl_oe_n[cpps_pkg::CPPS_D0] = (slv_w == cpps_pkg::CPPS_W_SERIAL)
                                        || !slv_doe_i[cpps_pkg::CPPS_D0];
      if (slv_w == cpps_pkg::CPPS_W_QUAD) begin
        nxt_st.sl_oe_n[cpps_pkg::CPPS_D2] = !slv_doe_i[cpps_pkg::CPPS_D2];
        nxt_st.sl_oe_n[cpps_pkg::CPPS_D3] = !slv_doe_i[cpps_pkg::CPPS_D3];
      end
    end
    if (i2c_act) begin
      nxt_st.sl_o[cpps_pkg::CPPS_D2]    = 1'b0;
      nxt_st.sl_o[cpps_pkg::CPPS_D3]    = 1'b0;
      nxt_st.sl_oe_n[cpps_pkg::CPPS_D2] = !i2c_scl_hold_i;
      nxt_st.sl_oe_n[cpps_pkg::CPPS_D3] = !i2c_sda_pull_i;
    end
    nxt_st.scl = i2c_act ? st_ff.sl_s2[cpps_pkg::CPPS_D2] : 1'b1;
    nxt_st.sda = i2c_act ? st_ff.sl_s2[cpps_pkg::CPPS_D3] : 1'b1;

    // master flash port
    nxt_st.m_clk      = mst_clk_i;
    nxt_st.m_sel      = mst_sel_n_i;
    nxt_st.m_clk_oe_n = (mst_w == cpps_pkg::CPPS_W_OFF);
    nxt_st.m_sel_oe_n = (mst_w == cpps_pkg::CPPS_W_OFF);
    nxt_st.ml_o       = mst_dout_i;
    nxt_st.ml_oe_n    = 4'hf;
    nxt_st.mst_din    = st_ff.ml_s2;
    if (mst_w == cpps_pkg::CPPS_W_SERIAL) begin
      nxt_st.ml_oe_n[cpps_pkg::CPPS_D0] = 1'b0;
    end else if (mst_w != cpps_pkg::CPPS_W_OFF) begin
      nxt_st.ml_oe_n[cpps_pkg::CPPS_D0] = !mst_doe_i[cpps_pkg::CPPS_D0];
      nxt_st.ml_oe_n[cpps_pkg::CPPS_D1] = !mst_doe_i[cpps_pkg::CPPS_D1];
      if (mst_w == cpps_pkg::CPPS_W_QUAD) begin
        nxt_st.ml_oe_n[cpps_pkg::CPPS_D2] = !mst_doe_i[cpps_pkg::CPPS_D2];
        nxt_st.ml_oe_n[cpps_pkg::CPPS_D3] = !mst_doe_i[cpps_pkg::CPPS_D3];
      end
    end
    // chain select: flow-through only; bypass data output not provided
    nxt_st.chain      = mst_sel_n_i;
    nxt_st.chain_oe_n = !(done_bit_i && cfg_complete_i);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= cpps_pkg::CPPS_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign mst_din_o                  = st_ff.mst_din;
  assign master_clk_o               = st_ff.m_clk;
  assign master_clk_oe_n_o          = st_ff.m_clk_oe_n;
  assign master_flash_select_n_o    = st_ff.m_sel;
  assign master_flash_select_oe_n_o = st_ff.m_sel_oe_n;
  assign master_lane_o              = st_ff.ml_o;
  assign master_lane_oe_n_o         = st_ff.ml_oe_n;
  assign chain_select_out_o         = st_ff.chain;
  assign chain_select_oe_n_o        = st_ff.chain_oe_n;
  assign slave_lane_o               = st_ff.sl_o;
  assign slave_lane_oe_n_o          = st_ff.sl_oe_n;
  assign slv_clk_rise_o             = slv_sel && tck_rise;
  assign slv_clk_fall_o             = slv_sel && tck_fall;
  assign slv_sel_o                  = slv_sel;
  assign slv_din_o                  = st_ff.slv_din;
  assign i2c_active_o               = i2c_act;
  assign i2c_scl_o                  = st_ff.scl;
  assign i2c_sda_o                  = st_ff.sda;
  assign tap_state_o                = st_ff.tap;
  assign jtag_ir_o                  = st_ff.ir;
  assign jtag_active_o              = jtag_act;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  tap_hold_a: assert property (!tck_rise |=> $stable(st_ff.tap))
    else $error("tap state moved without a tck rising edge");
  tap_tlr_a: assert property (jtag_act && tck_rise && st_ff.sel_s2
      && st_ff.tap == cpps_pkg::CPPS_TAP_TLR |=> st_ff.tap == cpps_pkg::CPPS_TAP_TLR)
    else $error("tap left reset with tms high");
  ir_shift_a: assert property (jtag_act && tck_rise
      && st_ff.tap == cpps_pkg::CPPS_TAP_SIR |=> st_ff.ir_sh[3] == $past(st_ff.sl_s2[0]))
    else $error("instruction shift did not take tdi");
  tdo_drive_a: assert property (jtag_act && tck_fall && st_ff.jen_s1
      |=> ##1 (slave_lane_oe_n_o[1] == !($past(tap_shift, 2))))
    else $error("tdo enable does not follow shift states");
  mst_serial_a: assert property (mst_w == cpps_pkg::CPPS_W_SERIAL
      |=> !master_lane_oe_n_o[0] && master_lane_o[0] == $past(mst_dout_i[0]))
    else $error("master lane 0 not driven in serial mode");
  mst_in_a: assert property (mst_w == cpps_pkg::CPPS_W_SERIAL |=> master_lane_oe_n_o[1])
    else $error("master lane 1 driven in serial mode");
  mst_quad_a: assert property (mst_w != cpps_pkg::CPPS_W_QUAD
      |=> master_lane_oe_n_o[3] && master_lane_oe_n_o[2])
    else $error("master lanes 2 and 3 driven outside quad");
  chain_sel_a: assert property (!chain_select_oe_n_o |-> $past(done_bit_i && cfg_complete_i))
    else $error("chain select driven before configuration complete");
  slv_desel_a: assert property (!jtag_act && !i2c_act && st_ff.sel_s2
      ##1 (!jtag_act && !i2c_act) |-> slave_lane_oe_n_o == 4'hf)
    else $error("slave lanes driven while deselected");
  jtag_excl_a: assert property (jtag_act |-> !slv_sel_o && !i2c_active_o)
    else $error("slave function active in jtag role");

  tap_sdr_c: cover property (st_ff.tap == cpps_pkg::CPPS_TAP_SDR ##1 !slave_lane_oe_n_o[1]);
  mst_quad_c: cover property (mst_w == cpps_pkg::CPPS_W_QUAD ##1 !master_lane_oe_n_o[3]);
  i2c_pull_c: cover property (i2c_act && i2c_sda_pull_i ##1 !slave_lane_oe_n_o[3]);
  chain_c: cover property ($fell(chain_select_oe_n_o));

endmodule : cpps_top
`default_nettype wire

/* File: verification/cpps_far_model.sv */
// far side model: jtag or spi host on slave pins, flash on master lanes
`timescale 1ns/1ps
`default_nettype none
module cpps_far_model (
  input  wire logic  mclk_i,
  output logic       tck_o,
  output logic       sel_n_o,
  output logic [3:0] host_lane_o,
  output logic [3:0] flash_lane_o
);
  // ************
  // link steps
  // ************
  initial begin
    tck_o = 1'b0;
    sel_n_o = 1'b1;
    host_lane_o = 4'hf;
    flash_lane_o = 4'h0;
  end
  // one clock pulse, select or tms set up before the rise
  task automatic step(input logic sel_n, input logic [3:0] d, input int low_hold);
    @(posedge mclk_i);
    sel_n_o <= sel_n;
    host_lane_o <= d;
    repeat (4) @(posedge mclk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    tck_o <= 1'b0;
    repeat (low_hold) @(posedge mclk_i);
  endtask : step
  task automatic flash(input logic [3:0] d);
    @(posedge mclk_i);
    flash_lane_o <= d;
  endtask : flash
endmodule : cpps_far_model
`default_nettype wire

/* File: verification/cpps_top_tb_top.sv */
// self-checking bench for the configuration pin sharing block
`timescale 1ns/1ps
`default_nettype none
module cpps_top_tb_top;
  // ************
  // signals
  // ************
  logic mclk_i, rst_i, user_mode_i, done_bit_i, cfg_complete_i, jtag_en_pin_i;
  logic mst_clk_i, mst_sel_n_i, slave_port_clock_i, slave_port_select_n_i;
  logic i2c_scl_hold_i, i2c_sda_pull_i, master_clk_o, master_clk_oe_n_o;
  logic master_flash_select_n_o, master_flash_select_oe_n_o, chain_select_out_o;
  logic chain_select_oe_n_o, slv_clk_rise_o, slv_clk_fall_o, slv_sel_o;
  logic i2c_active_o, i2c_scl_o, i2c_sda_o, jtag_active_o;
  cpps_pkg::cpps_mode_e cfg_mode_i;
  cpps_pkg::cpps_keep_s keep_after_boot_bits_i;
  cpps_pkg::cpps_tap_e  tap_state_o;
  cpps_pkg::cpps_lane_t mst_dout_i, mst_doe_i, master_lane_i, slave_lane_i;
  cpps_pkg::cpps_lane_t slv_dout_i, slv_doe_i;
  logic [3:0] mst_din_o, master_lane_o, master_lane_oe_n_o, slave_lane_o;
  logic [3:0] slave_lane_oe_n_o, slv_din_o, jtag_ir_o, host_lane, flash_lane, d, e, f;
  typedef struct packed {logic [3:0] sel; logic [15:0] val;} cpps_note_s;
  cpps_note_s notes[$];
  cpps_note_s cur;
  logic [8:0] m;
  event       obs_ev;
  int         seed = 32'h3a90e876;
  int         mismatches = 0;
  int         num_checks = 0;
  logic [63:0] stv = 64'h1fcbbbba92100000;
  logic [15:0] tms = 16'h60df;
  assign slave_lane_i = (slave_lane_oe_n_o & host_lane) | (~slave_lane_oe_n_o & slave_lane_o);
  assign master_lane_i = (master_lane_oe_n_o & flash_lane) | (~master_lane_oe_n_o & master_lane_o);
  cpps_top cpps_top_inst (.*);
  cpps_far_model cpps_far_model_inst (.mclk_i(mclk_i), .tck_o(slave_port_clock_i),
    .sel_n_o(slave_port_select_n_i), .host_lane_o(host_lane), .flash_lane_o(flash_lane));
  // ************
  // checking
  // ************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic note(input logic [3:0] sel, input logic [15:0] exp);
    notes.push_back('{sel, exp});
    ->obs_ev;
  endtask : note
  function automatic logic [15:0] obs(input logic [3:0] sel);
    case (sel)
      4'h0: obs = {7'h0, master_clk_oe_n_o, master_lane_oe_n_o,
                   master_lane_o & ~master_lane_oe_n_o};
      4'h1: obs = {12'h0, mst_din_o};
      4'h2: obs = {14'h0, chain_select_oe_n_o, chain_select_out_o & ~chain_select_oe_n_o};
      4'h3: obs = {12'h0, tap_state_o};
      4'h4: obs = {14'h0, slave_lane_oe_n_o[1], slave_lane_o[1] & ~slave_lane_oe_n_o[1]};
      4'h5: obs = {12'h0, jtag_ir_o};
      4'h6: obs = {12'h0, slv_din_o};
      4'h7: obs = {7'h0, slv_sel_o, slave_lane_oe_n_o, slave_lane_o & ~slave_lane_oe_n_o};
      4'h9: obs = {13'h0, master_clk_o, master_flash_select_n_o, master_flash_select_oe_n_o};
      default: obs = {12'h0, i2c_active_o, i2c_scl_o, i2c_sda_o, jtag_active_o};
    endcase
  endfunction : obs
  function automatic logic [8:0] mexp(input logic [1:0] w, input logic [3:0] oe_r,
                                      input logic [3:0] dv);
    logic [3:0] oe;
    oe = (w == 2'h3) ? oe_r : (w == 2'h2) ? {2'b00, oe_r[1:0]} : {3'b000, w == 2'h1};
    return {w == 2'h0, ~oe, dv & oe};
  endfunction : mexp
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    forever begin
      @(obs_ev);
      while (notes.size() > 0) begin
        cur = notes.pop_front();
        check(obs(cur.sel), cur.val);
      end
    end
  end
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    finish_test();
  end
  // ************
  // scenarios
  // ************
  initial begin
    {rst_i, user_mode_i, done_bit_i, cfg_complete_i, jtag_en_pin_i, mst_clk_i} = 6'h20;
    {mst_sel_n_i, i2c_scl_hold_i, i2c_sda_pull_i} = 3'h4;
    cfg_mode_i = cpps_pkg::CPPS_MODE_NONE;
    keep_after_boot_bits_i = '0;
    {mst_dout_i, mst_doe_i, slv_dout_i, slv_doe_i} = '0;
    cyc(8);
    note(0, 16'h01f0);
    note(3, 16'h0000);
    note(5, 16'h000f);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      {d, e, f} = 12'($random(seed));
      @(posedge mclk_i);
      user_mode_i <= i[2];
      cfg_mode_i <= i[2] ? cpps_pkg::cpps_mode_e'(d[2:0]) : cpps_pkg::cpps_mode_e'(i[1:0]);
      keep_after_boot_bits_i <= cpps_pkg::cpps_keep_s'({i[2] ? i[1:0] : d[1:0], e[1:0], f[0]});
      {mst_dout_i, mst_doe_i, mst_clk_i} <= {d, e, f[1]};
      cpps_far_model_inst.flash(f);
      cyc(5);
      m = mexp(i[1:0], e, d);
      note(0, {7'h0, m});
      note(1, {12'h0, m[3:0] | (m[7:4] & f)});
      note(9, {13'h0, f[1], 1'b1, i[1:0] == 2'h0});
    end
    for (int i = 0; i < 4; i++) begin
      d = 4'($random(seed));
      @(posedge mclk_i);
      {done_bit_i, cfg_complete_i, mst_sel_n_i} <= {i[0], i[1], d[0]};
      cyc(3);
      note(2, {14'h0, ~&i[1:0], d[0] & (&i[1:0])});
    end
    @(posedge mclk_i);
    {user_mode_i, jtag_en_pin_i} <= 2'b01;
    cfg_mode_i <= cpps_pkg::CPPS_MODE_NONE;
    d = 4'($random(seed));
    cyc(4);
    for (int i = 0; i < 16; i++) begin
      cpps_far_model_inst.step(tms[i], {3'b111, (i > 9 && i < 14) ? d[i-10] : 1'b1},
                               (i == 11) ? 60 : 6);
      #1;
      note(3, {12'h0, stv[i*4 +: 4]});
      if ((i > 8 && i < 14) || i == 5) note(4, {14'h0, i == 13 || i == 5, i == 9});
    end
    note(5, {12'h0, d});
    @(posedge mclk_i);
    jtag_en_pin_i <= 1'b0;
    cpps_far_model_inst.step(1'b1, 4'hf, 6);
    #1;
    note(3, 16'h0001);
    note(8, 16'h0006);
    for (int i = 0; i < 3; i++) begin
      {d, e} = 8'($random(seed));
      @(posedge mclk_i);
      cfg_mode_i <= cpps_pkg::cpps_mode_e'(4 + i);
      {slv_dout_i, slv_doe_i} <= {e, (i == 2) ? 4'h0 : 4'hf};
      cpps_far_model_inst.step(1'b0, d, 6);
      #1;
      f = (i == 0) ? 4'b0010 : (i == 1) ? 4'b0011 : 4'h0;
      note(7, {7'h0, 1'b1, ~f, e & f});
      if (i == 2) note(6, {12'h0, d});
      cpps_far_model_inst.step(1'b1, 4'hf, 6);
      #1;
      note(7, 16'h00f0);
    end
    d = 4'($random(seed));
    @(posedge mclk_i);
    cfg_mode_i <= cpps_pkg::CPPS_SLV_I2C;
    cpps_far_model_inst.step(1'b1, {d[1:0], 2'b11}, 6);
    #1;
    note(8, {12'h0, 1'b1, d[0], d[1], 1'b0});
    @(posedge mclk_i);
    {i2c_scl_hold_i, i2c_sda_pull_i} <= 2'b11;
    cyc(4);
    note(7, 16'h0030);
    @(posedge mclk_i);
    {i2c_scl_hold_i, i2c_sda_pull_i, jtag_en_pin_i} <= 3'b001;
    cyc(6);
    note(8, 16'h0007);
    cyc(2);
    finish_test();
  end
endmodule : cpps_top_tb_top
`default_nettype wire
